// ==== hw/svld_top.sv ====
`default_nettype none
module svld_top
    import svld_pkg::*;
#(
    parameter int SETTLE_CYC = SVLD_SETTLE_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        comp_below_i,
    output logic             analog_enable_o,
    output svld_ctrl_t       analog_ctrl_o,
    output logic             undervoltage_irq_o,
    output logic [7:0]       irq_mid_bank_o
);
    if (SETTLE_CYC < 1) begin : g_bad_settle
        $error("SETTLE_CYC must be at least 1");
    end

    function automatic logic is_known(input logic [3:0] a);
        return a == SVLD_ADDR_CTRL || a == SVLD_ADDR_STAT ||
               a == SVLD_ADDR_IRQST || a == SVLD_ADDR_IRQMSK;
    endfunction

    svld_ctrl_t  ctrl;
    svld_state_t state;
    logic        detector_enable;
    logic        undervoltage_flag;
    logic        result_valid_flag;
    logic        irq_status;
    logic        irq_mask;
    logic        settle_done;
    logic        uv_event;

    // Write channel: address and data held until both present
    logic [3:0]  aw_addr;
    logic        aw_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_have;
    logic        wr_fire;

    assign s_axi_awready = !aw_have && !s_axi_bvalid;
    assign s_axi_wready  = !w_have && !s_axi_bvalid;
    assign wr_fire       = aw_have && w_have && !s_axi_bvalid;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            aw_have <= 1'b0;
            aw_addr <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            w_have <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SVLD_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_known(aw_addr) ? SVLD_RESP_OKAY
                                              : SVLD_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_lane0;
    assign wr_lane0 = wr_fire && w_strb[0];

    // Control register
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ctrl <= '0;
        end else if (wr_lane0 && aw_addr == SVLD_ADDR_CTRL) begin
            ctrl.range_select   <= w_data[SVLD_RANGE_BIT];
            ctrl.threshold_trim <=
                w_data[SVLD_TRIM_LSB +: SVLD_TRIM_W];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            detector_enable <= 1'b0;
        end else if (wr_lane0 && aw_addr == SVLD_ADDR_STAT) begin
            detector_enable <= w_data[SVLD_EN_BIT];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            irq_mask <= 1'b0;
        end else if (wr_lane0 && aw_addr == SVLD_ADDR_IRQMSK) begin
            irq_mask <= w_data[SVLD_IRQ_BIT];
        end
    end

    svld_timer #(
        .CYCLES (SETTLE_CYC)
    ) u_timer (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .run_i   (detector_enable),
        .done_o  (settle_done)
    );

    // Detector sequence
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state <= SVLD_OFF;
        end else begin
            case (state)
                SVLD_OFF: begin
                    if (detector_enable) state <= SVLD_SETTLE;
                end
                SVLD_SETTLE: begin
                    if (!detector_enable) state <= SVLD_OFF;
                    else if (settle_done) state <= SVLD_VALID;
                end
                SVLD_VALID: begin
                    if (!detector_enable) state <= SVLD_OFF;
                end
                default: state <= SVLD_OFF;
            endcase
        end
    end

    assign result_valid_flag = (state == SVLD_VALID);

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !detector_enable || !result_valid_flag) begin
            undervoltage_flag <= 1'b0;
        end else begin
            undervoltage_flag <= comp_below_i;
        end
    end

    assign uv_event = result_valid_flag && detector_enable &&
                      comp_below_i && !undervoltage_flag;

    // Sticky event, set wins over write-one clear
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            irq_status <= 1'b0;
        end else if (uv_event) begin
            irq_status <= 1'b1;
        end else if (wr_lane0 && aw_addr == SVLD_ADDR_IRQST &&
                     w_data[SVLD_IRQ_BIT]) begin
            irq_status <= 1'b0;
        end
    end

    assign undervoltage_irq_o = irq_status && irq_mask;
    always_comb begin
        irq_mid_bank_o = 8'h00;
        irq_mid_bank_o[SVLD_IRQ_MID_POS] = undervoltage_irq_o;
    end

    assign analog_enable_o = detector_enable;
    assign analog_ctrl_o   = ctrl;

    // Read channel
    svld_stat_t stat_view;
    assign stat_view = '{undervoltage_flag, result_valid_flag,
                         detector_enable};

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= SVLD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= is_known(s_axi_araddr) ? SVLD_RESP_OKAY
                                                   : SVLD_RESP_SLVERR;
            case (s_axi_araddr)
                SVLD_ADDR_CTRL:   s_axi_rdata <= {28'h0, ctrl};
                SVLD_ADDR_STAT:   s_axi_rdata <= {29'h0, stat_view};
                SVLD_ADDR_IRQST:  s_axi_rdata <= {31'h0, irq_status};
                SVLD_ADDR_IRQMSK: s_axi_rdata <= {31'h0, irq_mask};
                default:          s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    // Checks
    // Valid lags the enable register by one cycle when it drops
    a_valid_needs_en: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        result_valid_flag |-> $past(detector_enable))
        else $error("valid set while disabled");
    a_disable_clears: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        $fell(detector_enable) |=> !result_valid_flag && !undervoltage_flag)
        else $error("disable did not clear flags");
    a_valid_not_early: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        $rose(detector_enable) |-> !result_valid_flag[*2])
        else $error("valid rose too early");
    a_valid_on_done: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        state == SVLD_SETTLE && detector_enable && settle_done
            |=> result_valid_flag)
        else $error("valid missing after settle");
    a_valid_after_done: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        $rose(result_valid_flag) |-> $past(settle_done))
        else $error("valid without settle time");
    a_event_sets_irq: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        uv_event |=> irq_status)
        else $error("event lost");
    a_irq_sticky: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        irq_status && !(wr_lane0 && aw_addr == SVLD_ADDR_IRQST)
            |=> irq_status)
        else $error("status lost without clear");
    a_irq_edge_only: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        $rose(irq_status) |-> $past(uv_event))
        else $error("status set without edge");
    a_result_follows: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        result_valid_flag && detector_enable && $past(result_valid_flag)
            |-> undervoltage_flag == $past(comp_below_i))
        else $error("result not tracking comparator");
    a_result_needs_valid: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        !result_valid_flag |=> !undervoltage_flag)
        else $error("result set while not valid");
    a_enable_write: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        wr_lane0 && aw_addr == SVLD_ADDR_STAT
            |=> detector_enable == $past(w_data[SVLD_EN_BIT]))
        else $error("enable write lost");
    a_irq_gated_mask: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        $onehot0(irq_mid_bank_o) &&
            irq_mid_bank_o[SVLD_IRQ_MID_POS] == (irq_status && irq_mask))
        else $error("irq not masked or mapped");
    a_analog_off: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        !detector_enable |-> !analog_enable_o ##1 state != SVLD_VALID)
        else $error("analog on while disabled");

    c_valid_reached: cover property (@(posedge mclk_i)
        disable iff (!rst_b_i) $rose(result_valid_flag));
    c_irq_fired: cover property (@(posedge mclk_i)
        disable iff (!rst_b_i) $rose(undervoltage_irq_o));
    c_disable_valid: cover property (@(posedge mclk_i)
        disable iff (!rst_b_i) result_valid_flag ##1 !detector_enable);
    c_bad_addr: cover property (@(posedge mclk_i)
        disable iff (!rst_b_i) s_axi_bvalid &&
        s_axi_bresp == SVLD_RESP_SLVERR);
endmodule
`default_nettype wire

// ==== hw/svld_pkg.sv ====
`default_nettype none
package svld_pkg;
    localparam logic [3:0] SVLD_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] SVLD_ADDR_STAT   = 4'h4;
    localparam logic [3:0] SVLD_ADDR_IRQST  = 4'h8;
    localparam logic [3:0] SVLD_ADDR_IRQMSK = 4'hc;
    localparam int SVLD_RANGE_BIT  = 3;
    localparam int SVLD_TRIM_LSB   = 0;
    localparam int SVLD_TRIM_W     = 3;
    localparam int SVLD_EN_BIT     = 0;
    localparam int SVLD_VALID_BIT  = 1;
    localparam int SVLD_RESULT_BIT = 2;
    localparam int SVLD_IRQ_BIT    = 0;
    localparam int SVLD_IRQ_MID_POS = 2;
    localparam logic [1:0] SVLD_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SVLD_RESP_SLVERR = 2'h2;
    localparam int SVLD_SETTLE_US = 2000;
    localparam int SVLD_CLK_MHZ   = 100;
    localparam int SVLD_SETTLE_CYC = SVLD_SETTLE_US * SVLD_CLK_MHZ;
    typedef struct packed {
        logic       range_select;
        logic [2:0] threshold_trim;
    } svld_ctrl_t;
    typedef struct packed {
        logic undervoltage_flag;
        logic result_valid_flag;
        logic detector_enable;
    } svld_stat_t;
    typedef enum logic [2:0] {
        SVLD_OFF    = 3'b001,
        SVLD_SETTLE = 3'b010,
        SVLD_VALID  = 3'b100
    } svld_state_t;
endpackage
`default_nettype wire

// ==== hw/svld_timer.sv ====
`default_nettype none
module svld_timer
    import svld_pkg::*;
#(
    parameter int CYCLES = SVLD_SETTLE_CYC
) (
    input  wire logic mclk_i,
    input  wire logic rst_b_i,
    input  wire logic run_i,
    output logic      done_o
);
    localparam int W = $clog2(CYCLES + 1);
    if (CYCLES < 1) begin : g_bad_cycles
        $error("CYCLES must be at least 1");
    end
    logic [W-1:0] count;
    // Restarts from zero whenever run drops
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !run_i) begin
            count <= '0;
        end else if (count != W'(CYCLES)) begin
            count <= count + W'(1);
        end
    end
    assign done_o = run_i && (count == W'(CYCLES));
endmodule
`default_nettype wire

// ==== verification/tb_supply_voltage_level_detector.sv ====
`default_nettype none
module tb_supply_voltage_level_detector
    import svld_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SETTLE = 20;
    logic        mclk_i     = 1'b0;
    logic        rst_b_i    = 1'b0;
    logic [3:0]  awaddr     = 4'h0;
    logic        awvalid    = 1'b0;
    logic [31:0] wdata      = 32'h0;
    logic [3:0]  wstrb      = 4'hf;
    logic        wvalid     = 1'b0;
    logic [3:0]  araddr     = 4'h0;
    logic        arvalid    = 1'b0;
    logic        comp_below = 1'b0;
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        an_en;
    svld_ctrl_t  an_ctrl;
    logic        irq;
    logic [7:0]  irq_bank;
    logic [31:0] rd;
    logic [1:0]  rsp;
    int          error_cnt  = 0;
    int          num_checks = 0;
    int          cyc        = 0;

    always #5 mclk_i = ~mclk_i;

    svld_top #(.SETTLE_CYC(SETTLE)) dut_u (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .comp_below_i(comp_below), .analog_enable_o(an_en),
        .analog_ctrl_o(an_ctrl), .undervoltage_irq_o(irq),
        .irq_mid_bank_o(irq_bank)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Bready and rready stay high, so each ends one edge after the response edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge mclk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                rsp = bresp;
                break;
            end
        end
        @(posedge mclk_i);
    endtask

    task automatic rdr(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge mclk_i);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                rsp = rresp;
                break;
            end
        end
        @(posedge mclk_i);
    endtask

    task automatic t_reset;
        chk({29'h0, awready, wready, arready}, 32'h7);
        for (int i = 0; i < 4; i++) begin
            rdr(4'(i * 4));
            chk(rd, 32'h0);
        end
        chk({18'h0, an_en, an_ctrl, irq, irq_bank}, 32'h0);
    endtask

    task automatic t_ctrl;
        wr(SVLD_ADDR_CTRL, 32'hffff_fff5);
        rdr(SVLD_ADDR_CTRL);
        chk(rd, 32'h5);
        chk({28'h0, an_ctrl}, 32'h5);
        wr(SVLD_ADDR_CTRL, 32'ha);
        chk({28'h0, an_ctrl}, 32'ha);
        wr(4'h2, 32'hf);
        chk({30'h0, rsp}, {30'h0, SVLD_RESP_SLVERR});
        rdr(4'h2);
        chk({rd[29:0], rsp}, {30'h0, SVLD_RESP_SLVERR});
        rdr(SVLD_ADDR_CTRL);
        chk(rd, 32'ha);
        // Lane 0 strobe low: the write must leave control alone
        wstrb <= 4'he;
        wr(SVLD_ADDR_CTRL, 32'h5);
        wstrb <= 4'hf;
        chk({28'h0, an_ctrl}, 32'ha);
    endtask

    task automatic t_off;
        comp_below <= 1'b1;
        repeat (5) @(posedge mclk_i);
        rdr(SVLD_ADDR_IRQST);
        chk(rd, 32'h0);
        chk({31'h0, an_en}, 32'h0);
        comp_below <= 1'b0;
    endtask

    task automatic t_enable;
        // Status shows enable alone while settling, then valid once the settle time ends
        wr(SVLD_ADDR_STAT, 32'hff);
        chk({31'h0, an_en}, 32'h1);
        repeat (12) @(posedge mclk_i);
        rdr(SVLD_ADDR_STAT);
        chk(rd, 32'h1);
        for (int i = 0; i < 20 && rd[1] !== 1'b1; i++) rdr(SVLD_ADDR_STAT);
        chk(rd, 32'h3);
    endtask

    task automatic t_irq;
        wr(SVLD_ADDR_IRQMSK, 32'h1);
        comp_below <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk({23'h0, irq, irq_bank}, 32'h104);
        rdr(SVLD_ADDR_STAT);
        chk(rd, 32'h7);
        wr(SVLD_ADDR_IRQST, 32'h1);
        repeat (3) @(posedge mclk_i);
        chk({31'h0, irq}, 32'h0);
        comp_below <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rdr(SVLD_ADDR_STAT);
        chk(rd, 32'h3);
        comp_below <= 1'b1;
        repeat (3) @(posedge mclk_i);
        wr(SVLD_ADDR_IRQMSK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rdr(SVLD_ADDR_IRQST);
        chk(rd, 32'h1);
        wr(SVLD_ADDR_IRQMSK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(SVLD_ADDR_IRQST, 32'h1);
    endtask

    task automatic t_disable;
        wr(SVLD_ADDR_STAT, 32'h0);
        chk({31'h0, an_en}, 32'h0);
        rdr(SVLD_ADDR_STAT);
        chk(rd, 32'h0);
        wr(SVLD_ADDR_STAT, 32'h1);
        repeat (12) @(posedge mclk_i);
        rdr(SVLD_ADDR_STAT);
        chk(rd, 32'h1);
        comp_below <= 1'b0;
    endtask

    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        @(posedge mclk_i);
        t_reset();
        t_ctrl();
        t_off();
        t_enable();
        t_irq();
        t_disable();
        give_verdict();
    end
endmodule
`default_nettype wire
